// file: common/tpw_cfg.svh
// Register map, field layout and reset constants for the three-phase PWM block
`ifndef TPW_CFG_SVH
`define TPW_CFG_SVH
// Register indices; byte address is four times the index
`define TPW_A_MAIN   13'h1fae
`define TPW_A_CKSEL  13'h1faf
`define TPW_A_OUT    13'h1fb2
`define TPW_A_DT     13'h1fbe
`define TPW_A_CNT    13'h1fc0
`define TPW_A_PRD    13'h1fc1
`define TPW_A_U_COMPARE_REG   13'h1fc2
`define TPW_A_V_COMPARE_REG   13'h1fc3
`define TPW_A_W_COMPARE_REG   13'h1fc4
// Main control fields
`define TPW_B_HLF    7
`define TPW_B_DTY    6
`define TPW_B_UPPER_SIDE_POLARITY   5
`define TPW_B_POLL   4
`define TPW_F_IRQ_PERIOD_DIVIDER   3:2
`define TPW_B_MODE   1
`define TPW_B_EN     0
// Commutation output fields (stored bits 14:0, bit 15 is the direction flag)
`define TPW_F_EXPECTED_POSITION_VALUE  14:12
`define TPW_B_PERIOD_SYNC_SELECT  11
`define TPW_F_OTYPE  10:8
`define TPW_F_SYNC_SOURCE_SELECT  7:6
`define TPW_F_OC     5:0
// Sync source codes
`define TPW_SS_ASYNC 2'h0
`define TPW_SS_POS   2'h1
`define TPW_SS_TMR1  2'h2
`define TPW_SS_TMR2  2'h3
// Reset values
`define TPW_RST_MAIN 8'h00
`define TPW_RST_CK   2'h0
`define TPW_RST_DT   6'h00
`define TPW_RST_OUT  15'h0000
`define TPW_RST_PRD  12'hfff
`define TPW_RST_CMP  12'h000
// Dead time unit in system clocks
`define TPW_DT_UNIT  8
`endif

// file: common/tpw_pkg.sv
// Types shared by the three-phase PWM block
package tpw_pkg;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]       ctrl;
        logic [1:0]       ck;
        logic [5:0]       dt;
        logic [14:0]      mo_wr;
        logic [2:0]       expected_position_value_a;
        logic [2:0]       otype_a;
        logic [5:0]       oc_a;
        logic             pend;
        logic             wt;
        logic [3:0]       pre;
        logic [11:0]      cnt;
        logic             dir;
        logic [11:0]      prd_b;
        logic [11:0]      prd_a;
        logic [2:0][11:0] cmp_b;
        logic [2:0][11:0] cmp_a;
        logic [2:0]       irqc;
        logic             irq;
        logic [5:0]       on;
        logic [5:0][8:0]  dtc;
        logic [2:0]       up_o;
        logic [2:0]       lo_o;
        logic [31:0]      rdata;
        logic             wait_q;
    } tpw_state_t;

endpackage

// file: core/tpw_top.sv
// Three-phase PWM waveform synthesis with Avalon-MM register access
`timescale 1ns/1ns
`include "tpw_cfg.svh"

module tpw_top
    import tpw_pkg::*;
#(
    parameter int DT_UNIT = `TPW_DT_UNIT
)
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    input  wire logic [12:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic        i_pos_evt,
    input  wire logic        i_tmr1_evt,
    input  wire logic        i_tmr2_evt,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic [2:0]       o_upper,
    output logic [2:0]       o_lower,
    output logic [2:0]       o_expected_pos,
    output logic             o_period_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Parameter check
    generate
        if (DT_UNIT < 1 || DT_UNIT > 8)
        begin : g_bad_unit
            $error("DT_UNIT must lie in 1..8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic [1:0] rs_q;
    logic       rst_n;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rs_q <= 2'h0;
        else
            rs_q <= {rs_q[0], 1'b1};
    end
    assign rst_n = rs_q[1];

    ////////////////////////////////////////////////////////////////////////
    // State and helpers
    tpw_state_t s;
    tpw_state_t n;

    logic        en;
    logic        cmode;
    logic [3:0]  ck_mask;
    logic [2:0]  ip_mask;
    logic        tick;
    logic        peak;
    logic        bnd;
    logic        half;
    logic [1:0]  ss;
    logic        ev;
    logic        apply;
    logic        to_wait;
    logic [5:0]  req;
    logic [8:0]  dt_cyc;

    assign en    = s.ctrl[`TPW_B_EN];
    assign cmode = s.ctrl[`TPW_B_MODE];

    // Prescaler divides fc by 2, 4, 8 or 16
    assign ck_mask = {s.ck == 2'h3, s.ck[1], |s.ck, 1'b1};
    assign tick    = en && ((s.pre & ck_mask) == ck_mask);

    // Peak of the carrier and period boundary
    assign peak = s.cnt >= s.prd_a;
    assign bnd  = tick && (cmode ? (s.dir && s.cnt == 12'h000) : peak);
    assign half = tick && cmode && !s.dir && peak;

    // Interrupt divider mask
    assign ip_mask = {s.ctrl[`TPW_F_IRQ_PERIOD_DIVIDER] == 2'h3, s.ctrl[3], |s.ctrl[`TPW_F_IRQ_PERIOD_DIVIDER]};

    // Selected sync event, source takes effect as soon as written
    assign ss = s.mo_wr[`TPW_F_SYNC_SOURCE_SELECT];
    always_comb
    begin
        case (ss)
            `TPW_SS_ASYNC: ev = 1'b1;
            `TPW_SS_POS:   ev = i_pos_evt;
            `TPW_SS_TMR1:  ev = i_tmr1_evt;
            `TPW_SS_TMR2:  ev = i_tmr2_evt;
            default:       ev = 1'b0;
        endcase
    end

    // Apply now, or park until the next boundary when period sync is set
    assign to_wait = s.pend && ev && s.mo_wr[`TPW_B_PERIOD_SYNC_SELECT];
    assign apply   = (s.pend && ev && !s.mo_wr[`TPW_B_PERIOD_SYNC_SELECT]) || (s.wt && bnd);

    assign dt_cyc = 9'(s.dt) * 9'(DT_UNIT);

    // Per-phase output requests before dead time
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ph
            logic [11:0] v_compare_reg;
            logic        pwm;
            logic [1:0]  oc;
            assign v_compare_reg = s.ctrl[`TPW_B_DTY] ? s.cmp_a[gi] : s.cmp_a[0];
            assign pwm  = s.cnt < v_compare_reg;
            assign oc   = s.oc_a[2*gi +: 2];
            // Level mode follows the code bits, PWM mode may force one side off
            assign req[gi] = en && (s.otype_a[gi] ? (oc != 2'h1) && pwm : oc[1]);
            assign req[3+gi] = en && (s.otype_a[gi] ? (oc != 2'h2) && !pwm : oc[0]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Merge of a 12-bit register with byte enables
    function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [11:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[11:8] = wd[11:8];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic [31:0] rd_v;
        rd_v = 32'h0000_0000;
        n = s;
        n.pre = s.pre + 4'h1;
        n.irq = 1'b0;

        // Carrier counter
        if (!en)
        begin
            n.pre   = 4'h0;
            n.cnt   = 12'h000;
            n.dir   = 1'b0;
            n.prd_a = s.prd_b;
            n.cmp_a = s.cmp_b;
        end
        else if (tick)
        begin
            if (!cmode)
            begin
                n.dir = 1'b0;
                n.cnt = peak ? 12'h000 : s.cnt + 12'h001;
            end
            else if (!s.dir)
            begin
                if (peak)
                    n.dir = 1'b1;
                else
                    n.cnt = s.cnt + 12'h001;
            end
            else if (s.cnt == 12'h000)
                n.dir = 1'b0;
            else
                n.cnt = s.cnt - 12'h001;
        end

        // Edge mode never reports counting down
        if (!cmode)
            n.dir = 1'b0;

        // Buffered period and compare values load at the boundary
        if (bnd)
        begin
            n.prd_a = s.prd_b;
            n.cmp_a = s.cmp_b;
            n.irqc  = s.irqc + 3'h1;
            if ((s.irqc & ip_mask) == ip_mask)
                n.irq = 1'b1;
        end
        if (half && s.ctrl[`TPW_B_HLF] && s.ctrl[`TPW_F_IRQ_PERIOD_DIVIDER] == 2'h0)
            n.irq = 1'b1;
        if (!en)
            n.irqc = 3'h0;

        // Commutation update
        if (apply)
        begin
            n.expected_position_value_a = s.mo_wr[`TPW_F_EXPECTED_POSITION_VALUE];
            n.otype_a = s.mo_wr[`TPW_F_OTYPE];
            n.oc_a    = s.mo_wr[`TPW_F_OC];
            n.pend    = 1'b0;
            n.wt      = 1'b0;
        end
        else if (to_wait)
        begin
            n.pend = 1'b0;
            n.wt   = 1'b1;
        end

        // Dead time delays each turn-on, turn-off is immediate
        for (int k = 0; k < 6; k++)
        begin
            if (!req[k])
            begin
                n.on[k]  = 1'b0;
                n.dtc[k] = 9'h000;
            end
            else if (s.dtc[k] >= dt_cyc)
                n.on[k] = 1'b1;
            else
                n.dtc[k] = s.dtc[k] + 9'h001;
        end

        // Pin levels from polarity
        n.up_o = s.on[2:0] ~^ {3{s.ctrl[`TPW_B_UPPER_SIDE_POLARITY]}};
        n.lo_o = s.on[5:3] ~^ {3{s.ctrl[`TPW_B_POLL]}};

        // Read data mux
        case (i_avs_address)
            `TPW_A_MAIN:  rd_v = {24'h0, s.ctrl};
            `TPW_A_CKSEL: rd_v = {30'h0, s.ck};
            // Direction bit forced low while in edge mode
            `TPW_A_OUT:   rd_v = {16'h0, s.dir && cmode, s.mo_wr};
            `TPW_A_DT:    rd_v = {26'h0, s.dt};
            `TPW_A_CNT:   rd_v = {20'h0, s.cnt};
            `TPW_A_PRD:   rd_v = {20'h0, s.prd_b};
            `TPW_A_U_COMPARE_REG:  rd_v = {20'h0, s.cmp_b[0]};
            `TPW_A_V_COMPARE_REG:  rd_v = {20'h0, s.cmp_b[1]};
            `TPW_A_W_COMPARE_REG:  rd_v = {20'h0, s.cmp_b[2]};
            default:      rd_v = 32'h0000_0000;
        endcase

        // Bus: one wait cycle, then the access completes
        if (s.wait_q)
        begin
            if (i_avs_read || i_avs_write)
            begin
                n.wait_q = 1'b0;
                n.rdata  = i_avs_read ? rd_v : 32'h0000_0000;
            end
        end
        else
        begin
            n.wait_q = 1'b1;
            if (i_avs_write)
            begin
                case (i_avs_address)
                    `TPW_A_MAIN:
                        if (i_avs_byteenable[0])
                            n.ctrl = i_avs_writedata[7:0];
                    `TPW_A_CKSEL:
                        if (i_avs_byteenable[0])
                            n.ck = i_avs_writedata[1:0];
                    `TPW_A_OUT:
                    begin
                        if (i_avs_byteenable[0])
                            n.mo_wr[7:0] = i_avs_writedata[7:0];
                        if (i_avs_byteenable[1])
                            n.mo_wr[14:8] = i_avs_writedata[14:8];
                        n.pend = 1'b1;
                    end
                    `TPW_A_DT:
                        if (i_avs_byteenable[0])
                            n.dt = i_avs_writedata[5:0];
                    `TPW_A_PRD:  n.prd_b = merge12(s.prd_b, i_avs_writedata, i_avs_byteenable);
                    `TPW_A_U_COMPARE_REG: n.cmp_b[0] = merge12(s.cmp_b[0], i_avs_writedata, i_avs_byteenable);
                    `TPW_A_V_COMPARE_REG: n.cmp_b[1] = merge12(s.cmp_b[1], i_avs_writedata, i_avs_byteenable);
                    `TPW_A_W_COMPARE_REG: n.cmp_b[2] = merge12(s.cmp_b[2], i_avs_writedata, i_avs_byteenable);
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s        <= '0;
            s.ctrl   <= `TPW_RST_MAIN;
            s.ck     <= `TPW_RST_CK;
            s.dt     <= `TPW_RST_DT;
            s.mo_wr  <= `TPW_RST_OUT;
            s.prd_b  <= `TPW_RST_PRD;
            s.prd_a  <= `TPW_RST_PRD;
            s.cmp_b  <= {3{`TPW_RST_CMP}};
            s.cmp_a  <= {3{`TPW_RST_CMP}};
            s.up_o   <= 3'h7;
            s.lo_o   <= 3'h7;
            s.wait_q <= 1'b1;
        end
        else
            s <= n;
    end

    // Outputs straight from the state register
    assign o_avs_readdata    = s.rdata;
    assign o_avs_waitrequest = s.wait_q;
    assign o_upper           = s.up_o;
    assign o_lower           = s.lo_o;
    assign o_expected_pos    = s.expected_position_value_a;
    assign o_period_irq      = s.irq;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n);

    // Direction and commutation update checks
    a_dir_edge_zero: assert property ($past(!cmode) |-> !s.dir)
        else $error("Direction flag set in edge mode");
    a_expected_position_value_apply: assert property ($changed(s.expected_position_value_a) |-> $past(apply))
        else $error("Expected position changed without an update");
    a_wait_boundary: assert property ($fell(s.wt) |-> $past(bnd)
                                      || $past(s.pend && ev && !s.mo_wr[`TPW_B_PERIOD_SYNC_SELECT]))
        else $error("Period-synced update left wait off a boundary");
    a_async_apply: assert property ((s.pend && ss == `TPW_SS_ASYNC && !s.mo_wr[`TPW_B_PERIOD_SYNC_SELECT] && s.wait_q)
                                    |=> !s.pend && s.oc_a == $past(s.mo_wr[`TPW_F_OC]))
        else $error("Immediate update not applied");
    // Carrier and buffer checks
    a_cnt_limit: assert property (s.cnt <= s.prd_a)
        else $error("Carrier counter beyond period");
    a_prd_load: assert property (bnd |=> s.prd_a == $past(s.prd_b) && s.cmp_a == $past(s.cmp_b))
        else $error("Buffers not loaded at boundary");
    a_tick_gap: assert property ((tick && s.ck != 2'h0) |=> !tick || $changed(s.ck))
        else $error("Counter clock faster than selected");
    // Interrupt, dead time and disable checks
    a_irq_cause: assert property (o_period_irq |-> $past(bnd || half))
        else $error("Interrupt without period event");
    a_dt_turn_on: assert property ($rose(s.on[0]) |-> $past(req[0]) && $past(s.dtc[0]) >= $past(dt_cyc))
        else $error("Output turned on before dead time");
    a_disable_idle: assert property (!en |=> s.cnt == 12'h000 && !s.irq)
        else $error("Counter running while disabled");
    a_irq_single: assert property (o_period_irq |=> !o_period_irq)
        else $error("Interrupt held for two cycles");
    a_half_center: assert property ((o_period_irq && !$past(bnd))
                                    |-> $past(cmode && s.ctrl[`TPW_B_HLF]))
        else $error("Half-period interrupt outside center mode");
    // Output settings move only on an update, writes stay pending
    a_oc_hold: assert property (!apply |=> $stable(s.oc_a) && $stable(s.otype_a) && $stable(s.expected_position_value_a))
        else $error("Output settings changed without an update");
    a_pend_on_write: assert property ((!s.wait_q && i_avs_write && i_avs_address == `TPW_A_OUT)
                                      |=> s.pend)
        else $error("Output control write not left pending");
    // Carrier pacing and turn at the peak
    a_tick_spaced: assert property (tick |=> !tick)
        else $error("Counter ticks on two clocks in a row");
    a_dir_peak: assert property ((tick && cmode && !s.dir && peak) |=> s.dir)
        else $error("Triangle carrier did not turn at its peak");
    // Register reads of counter and direction
    a_cnt_read: assert property ((s.wait_q && i_avs_read && i_avs_address == `TPW_A_CNT)
                                 |=> o_avs_readdata == {20'h0, $past(s.cnt)})
        else $error("Counter read returned a stale value");
    a_dir_read: assert property ((s.wait_q && i_avs_read && i_avs_address == `TPW_A_OUT && !cmode)
                                 |=> !o_avs_readdata[15])
        else $error("Direction flag read high in edge mode");
    // Disabled block keeps every switch off
    a_off_disabled: assert property (!en |=> s.on == 6'h00)
        else $error("Switch on while synthesis disabled");

    // Main scenarios reached
    c_center_bnd: cover property (bnd && cmode);
    c_sync_wait: cover property ($fell(s.wt));
    c_half_irq: cover property (o_period_irq && s.ctrl[`TPW_B_HLF]);
    c_lower_on: cover property ($rose(s.on[3]));
    c_pos_apply: cover property (apply && ss == `TPW_SS_POS);

endmodule

// file: bench/tpw_drv_model.sv
// Gate driver stage and event sources facing the PWM pins
`timescale 1ns/1ns
module tpw_drv_model
(
    input  wire logic       i_clk,
    input  wire logic       i_watch,
    input  wire logic [2:0] i_upper,
    input  wire logic [2:0] i_lower,
    output logic [2:0]      o_evt,
    output int              o_overlap
);
    logic [2:0] ev = 3'h0;
    int         n_both = 0;

    // Outputs of the model
    assign o_evt = ev;
    assign o_overlap = n_both;

    ////////////////////////////////////////////////////////////////
    // Active-high gates: a phase with both switches on shorts the rail
    always @(posedge i_clk)
        if (i_watch && (i_upper & i_lower) != 3'h0)
            n_both <= n_both + 1;

    // One-cycle event: 0 position, 1 timer 1, 2 timer 2
    task automatic pulse(input int k);
        @(posedge i_clk);
        ev[k] <= 1'b1;
        @(posedge i_clk);
        ev <= 3'h0;
    endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the three-phase PWM block
`timescale 1ns/1ns
`include "tpw_cfg.svh"
module testbench;
    import tpw_pkg::*;
    typedef struct {logic [7:0] m; logic [15:0] o; int u[3]; int l[3];} tpw_row_t;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [12:0] adr = 13'h0;
    logic        avs_rd = 1'b0;
    logic        avs_wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0]  be = 4'hf;
    logic        watch = 1'b0;
    logic [31:0] rdat;
    logic        wait_r;
    logic [2:0]  up;
    logic [2:0]  lo;
    logic [2:0]  epos;
    logic        irq;
    logic [2:0]  evt;
    logic [31:0] v;
    logic [8:0]  old;
    logic        d_or;
    logic        d_and;
    int          overlap;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          cu[3];
    int          cl[3];
    int          g1;
    int          g2;
    // Control, output word, then high-cycle counts per phase over 32 clocks, one edge-mode period or half a center-mode period
    tpw_row_t    rows[7] = '{
        '{8'h31, 16'h0700, '{8, 8, 8}, '{24, 24, 24}},
        '{8'h71, 16'h0700, '{8, 16, 24}, '{24, 16, 8}},
        '{8'h71, 16'h073f, '{8, 16, 24}, '{24, 16, 8}},
        '{8'h41, 16'h0700, '{24, 16, 8}, '{8, 16, 24}},
        '{8'h41, 16'h0709, '{32, 16, 8}, '{8, 32, 24}},
        '{8'h41, 16'h0009, '{32, 0, 32}, '{0, 32, 32}},
        '{8'h41, 16'h0036, '{0, 32, 0}, '{32, 0, 0}}
    };

    tpw_top #(.DT_UNIT(1)) i_tpw_top (
        .i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(avs_rd),
        .i_avs_write(avs_wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .i_pos_evt(evt[0]), .i_tmr1_evt(evt[1]), .i_tmr2_evt(evt[2]),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_r), .o_upper(up),
        .o_lower(lo), .o_expected_pos(epos), .o_period_irq(irq));

    tpw_drv_model i_tpw_drv_model (.i_clk(clk), .i_watch(watch), .i_upper(up),
        .i_lower(lo), .o_evt(evt), .o_overlap(overlap));

    ////////////////////////////////////////////////////////////////
    // 50 MHz clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Compare one value and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    // One Avalon access held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        avs_wr <= w;
        avs_rd <= !w;
        do
            @(posedge clk);
        while (wait_r !== 1'b0);
        v = rdat;
        avs_wr <= 1'b0;
        avs_rd <= 1'b0;
    endtask

    // Count high cycles of each pin over n clocks
    task automatic meas(input int n);
        cu = '{0, 0, 0};
        cl = '{0, 0, 0};
        repeat (n)
        begin
            @(posedge clk);
            for (int i = 0; i < 3; i++)
            begin
                cu[i] += up[i];
                cl[i] += lo[i];
            end
        end
    endtask

    // Clocks between interrupt pulses, second interval after a change
    task automatic gap(output int g);
        @(posedge clk iff irq === 1'b1);
        repeat (2)
        begin
            g = 0;
            do
            begin
                @(posedge clk);
                g++;
            end
            while (irq !== 1'b1);
        end
    endtask

    // Verdict
    task automatic close_out();
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        chk({wait_r, up, lo, epos, irq}, 11'b1_111_111_000_0);
        repeat (15) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(0, `TPW_A_MAIN, 0);
        chk(v, 0);
        bus(0, `TPW_A_PRD, 0);
        chk(v[11:0], 12'hfff);
        bus(1, 13'h0000, 32'h5a);
        bus(0, 13'h0000, 0);
        chk(v, 0);
        bus(1, `TPW_A_CNT, 32'h123);
        bus(0, `TPW_A_CNT, 0);
        chk(v, 0);
        $display("reset and map test done");
        // Period 16 ticks of 2 clocks, compares 4, 8, 12
        bus(1, `TPW_A_PRD, 15);
        bus(1, `TPW_A_U_COMPARE_REG, 4);
        bus(1, `TPW_A_V_COMPARE_REG, 8);
        bus(1, `TPW_A_W_COMPARE_REG, 12);
        for (int r = 0; r < 7; r++)
        begin
            bus(1, `TPW_A_MAIN, rows[r].m & 8'hfe);
            bus(1, `TPW_A_OUT, rows[r].o);
            bus(1, `TPW_A_MAIN, rows[r].m);
            repeat (80) @(posedge clk);
            meas(32);
            for (int i = 0; i < 3; i++)
            begin
                chk(cu[i], rows[r].u[i]);
                chk(cl[i], rows[r].l[i]);
            end
        end
        $display("waveform table test done");
        for (int k = 0; k < 4; k++)
        begin
            bus(1, `TPW_A_MAIN, 8'h01 | (k << 2));
            gap(g1);
            chk(g1, 32 << k);
        end
        for (int k = 1; k < 5; k++)
        begin
            bus(1, `TPW_A_MAIN, 8'h00);
            bus(1, `TPW_A_CKSEL, k & 3);
            bus(1, `TPW_A_MAIN, 8'h01);
            gap(g1);
            chk(g1, 32 << (k & 3));
        end
        bus(1, `TPW_A_PRD, 7);
        gap(g1);
        chk(g1, 16);
        bus(1, `TPW_A_PRD, 15);
        $display("interrupt and clock test done");
        bus(1, `TPW_A_MAIN, 8'h03);
        gap(g1);
        chk(g1, 64);
        bus(1, `TPW_A_MAIN, 8'h83);
        gap(g2);
        chk(2 * g2, g1);
        d_or = 1'b0;
        d_and = 1'b1;
        repeat (40)
        begin
            bus(0, `TPW_A_OUT, 0);
            d_or |= v[15];
            d_and &= v[15];
            bus(0, `TPW_A_CNT, 0);
            chk(v <= 15, 1);
        end
        chk({d_or, d_and}, 2'b10);
        bus(1, `TPW_A_MAIN, 8'h01);
        repeat (20)
        begin
            bus(0, `TPW_A_OUT, 0);
            chk(v[15], 0);
        end
        $display("center and direction test done");
        bus(1, `TPW_A_OUT, 16'h5009);
        repeat (5) @(posedge clk);
        chk({epos, up, lo}, 9'b101_101_110);
        old = 9'b101_101_110;
        for (int s = 1; s < 4; s++)
        begin
            bus(1, `TPW_A_OUT, {1'b0, s[2:0], 4'h0, s[1:0], 6'h00});
            i_tpw_drv_model.pulse(s % 3);
            repeat (5) @(posedge clk);
            chk({epos, up, lo}, old);
            i_tpw_drv_model.pulse(s - 1);
            repeat (5) @(posedge clk);
            old = {s[2:0], 6'h3f};
            chk({epos, up, lo}, old);
        end
        bus(1, `TPW_A_OUT, 16'h6880);
        @(posedge clk iff irq === 1'b1);
        i_tpw_drv_model.pulse(1);
        bus(1, `TPW_A_OUT, 16'h4880);
        repeat (5) @(posedge clk);
        chk(epos, 3);
        @(posedge clk iff irq === 1'b1);
        repeat (5) @(posedge clk);
        chk(epos, 4);
        $display("commutation sync test done");
        bus(1, `TPW_A_MAIN, 8'h70);
        bus(1, `TPW_A_DT, 8'h02);
        bus(1, `TPW_A_OUT, 16'h0700);
        bus(1, `TPW_A_MAIN, 8'h71);
        repeat (80) @(posedge clk);
        watch <= 1'b1;
        meas(32);
        watch <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            chk(cu[i], 6 + 8 * i);
            chk(cl[i], 22 - 8 * i);
        end
        chk(overlap, 0);
        bus(1, `TPW_A_MAIN, 8'h70);
        repeat (5) @(posedge clk);
        chk({up, lo}, 6'h00);
        $display("dead time and disable test done");
        bus(1, `TPW_A_MAIN, 8'h71);
        repeat (10) @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        chk({wait_r, up, lo, epos, irq}, 11'b1_111_111_000_0);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(0, `TPW_A_MAIN, 0);
        chk(v, 0);
        $display("mid-run reset test done");
        close_out();
    end
endmodule
